// [rsf_top.sv]
// Purpose: rgmii rx/tx sync fifos with start level and clock skew control
// Assumes: link clock is sampled by clk_i; mac clock close to local (ppm)
// Notes: companion msb bits arrive as inputs from their own register
`timescale 1ns/10ps
`default_nettype none
module rsf_top
  import rsf_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // companion register bits
  input wire logic rx_level_msb_i,
  input wire logic tx_level_msb_i,
  // transmit pins from mac
  input wire logic rgmii_txc_i,
  input wire logic [3:0] rgmii_txd_i,
  input wire logic rgmii_tx_ctl_i,
  // transmit data to core
  output logic tx_core_valid_o,
  output logic [RSF_DW-1:0] tx_core_data_o,
  // receive data from core
  input wire logic rx_core_valid_i,
  input wire logic [RSF_DW-1:0] rx_core_data_i,
  // receive pins to mac
  output logic rgmii_rxc_o,
  output logic [3:0] rgmii_rxd_o,
  output logic rgmii_rx_ctl_o
);
  // ****************************************
  // registers
  // ****************************************
  logic [15:0] ctrl_r;
  logic [3:0] sticky_r;
  logic ack_r;
  logic [31:0] rdat_r;

  wire logic req = wb_cyc_i && wb_stb_i && !ack_r;
  wire logic [7:0] widx = {2'b00, wb_adr_i[7:2]};
  wire logic hit_ctrl = (widx == RSF_IDX_CTRL);
  wire logic hit_stat = (widx == RSF_IDX_STAT);
  wire logic wr_ctrl = req && wb_we_i && hit_ctrl;
  wire logic wr_stat = req && wb_we_i && hit_stat && wb_sel_i[0];
  wire logic [15:0] lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic [15:0] wmask = lane_mask & RSF_CTRL_WMASK;
  wire logic [15:0] ctrl_nxt = (ctrl_r & ~wmask) | (wb_dat_i[15:0] & wmask);

  wire logic [2:0] rx_level = {rx_level_msb_i,
                               ctrl_r[RSF_RX_LVL_LSB+1:RSF_RX_LVL_LSB]};
  wire logic [2:0] tx_level = {tx_level_msb_i,
                               ctrl_r[RSF_TX_LVL_LSB+1:RSF_TX_LVL_LSB]};
  wire logic tx_aligned = ctrl_r[RSF_TX_ALIGN_BIT];
  wire logic rx_aligned = ctrl_r[RSF_RX_ALIGN_BIT];

  logic rx_ovf, rx_unf, tx_ovf, tx_unf, rx_run, tx_run;
  wire logic [3:0] events = {tx_unf, tx_ovf, rx_unf, rx_ovf};
  wire logic [3:0] clr = wr_stat ? wb_dat_i[3:0] : 4'h0;
  // a new event beats a simultaneous clear
  wire logic [3:0] sticky_nxt = (sticky_r & ~clr) | events;
  wire logic [31:0] stat_word = {26'h0, tx_run, rx_run, sticky_r};
  wire logic [31:0] rd_word = hit_ctrl ? {16'h0, ctrl_r} :
                              hit_stat ? stat_word : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= RSF_CTRL_RESET;
      sticky_r <= 4'h0;
      ack_r <= 1'b0;
      rdat_r <= 32'h0;
    end else begin
      ack_r <= req;
      sticky_r <= sticky_nxt;
      if (wr_ctrl) begin
        ctrl_r <= ctrl_nxt;
      end
      if (req && !wb_we_i) begin
        rdat_r <= rd_word;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ****************************************
  // transmit link sampling
  // ****************************************
  // clock and data share one pipeline so they keep their relation
  logic [2:0] txc_s_r;
  logic [RSF_DW-1:0] txd_s1_r, txd_s2_r, txd_s3_r, txd_s4_r;
  logic txc_lvl_r;

  wire logic txc_agree = (txc_s_r[1] == txc_s_r[2]);
  wire logic tx_rise = txc_agree && txc_s_r[2] && !txc_lvl_r;
  // aligned clock: data moved with the edge, so take the older sample
  wire logic [RSF_DW-1:0] tx_wdata = tx_aligned ? txd_s4_r : txd_s3_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txc_s_r <= 3'h0;
      txd_s1_r <= '0;
      txd_s2_r <= '0;
      txd_s3_r <= '0;
      txd_s4_r <= '0;
      txc_lvl_r <= 1'b0;
    end else begin
      txc_s_r <= {txc_s_r[1:0], rgmii_txc_i};
      txd_s1_r <= {rgmii_tx_ctl_i, rgmii_txd_i};
      txd_s2_r <= txd_s1_r;
      txd_s3_r <= txd_s2_r;
      txd_s4_r <= txd_s3_r;
      if (txc_agree) begin
        txc_lvl_r <= txc_s_r[2];
      end
    end
  end

  // ****************************************
  // local read timing
  // ****************************************
  logic [2:0] ph_r;
  wire logic rd_tick = (ph_r == 3'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_r <= 3'h0;
    end else begin
      ph_r <= (ph_r == RSF_DIV_LAST) ? 3'h0 : ph_r + 3'h1;
    end
  end

  // ****************************************
  // fifos
  // ****************************************
  rsf_fifo u_tx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(tx_rise),
    .wr_data_i(tx_wdata),
    .rd_tick_i(rd_tick),
    .start_level_i(tx_level),
    .rd_valid_o(tx_core_valid_o),
    .rd_data_o(tx_core_data_o),
    .running_o(tx_run),
    .overflow_o(tx_ovf),
    .underflow_o(tx_unf)
  );

  logic rx_valid;
  logic [RSF_DW-1:0] rx_data;

  rsf_fifo u_rx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(rx_core_valid_i),
    .wr_data_i(rx_core_data_i),
    .rd_tick_i(rd_tick),
    .start_level_i(rx_level),
    .rd_valid_o(rx_valid),
    .rd_data_o(rx_data),
    .running_o(rx_run),
    .overflow_o(rx_ovf),
    .underflow_o(rx_unf)
  );

  // ****************************************
  // receive pins
  // ****************************************
  logic [RSF_DW-1:0] rxd_r;
  logic rxc_r;

  wire logic rxc_aln = (ph_r >= RSF_ALN_LO) && (ph_r <= RSF_ALN_HI);
  wire logic rxc_shf = (ph_r >= RSF_SHF_LO) && (ph_r <= RSF_SHF_HI);
  // data changes at phase 1; the shifted clock rises two phases later, a quarter symbol in
  wire logic rxc_nxt = rx_aligned ? rxc_aln : rxc_shf;
  // gaps in the stream go out as idle symbols
  wire logic [RSF_DW-1:0] rxd_nxt = rx_valid ? rx_data : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxd_r <= '0;
      rxc_r <= 1'b0;
    end else begin
      rxc_r <= rxc_nxt;
      if (ph_r == RSF_ALN_LO) begin
        rxd_r <= rxd_nxt;
      end
    end
  end

  assign rgmii_rxc_o = rxc_r;
  assign rgmii_rxd_o = rxd_r[3:0];
  assign rgmii_rx_ctl_o = rxd_r[4];
endmodule : rsf_top
`default_nettype wire

// [rsf_pkg.sv]
// Purpose: constants for the rgmii sync fifo and clock skew control block
// Assumes: 20 MHz system clock, 400 ns link clock period
// Notes: register indices are word indices; byte address is four times
package rsf_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] RSF_IDX_CTRL = 8'h32;
  localparam logic [7:0] RSF_IDX_STAT = 8'h34;
  localparam logic [15:0] RSF_CTRL_RESET = 16'h00D0;
  localparam logic [15:0] RSF_CTRL_WMASK = 16'h0BFF;
  localparam int RSF_RX_LVL_LSB = 5;
  localparam int RSF_TX_LVL_LSB = 3;
  localparam int RSF_TX_ERR_MASK_BIT = 2;
  localparam int RSF_TX_ALIGN_BIT = 1;
  localparam int RSF_RX_ALIGN_BIT = 0;
  // status: sticky flags in 3:0, run state in 5:4
  localparam int RSF_ST_RX_OVF = 0;
  localparam int RSF_ST_RX_UNF = 1;
  localparam int RSF_ST_TX_OVF = 2;
  localparam int RSF_ST_TX_UNF = 3;
  localparam int RSF_ST_RX_RUN = 4;
  localparam int RSF_ST_TX_RUN = 5;
  // ****************************************
  // fifo shape
  // ****************************************
  localparam int RSF_DEPTH = 8;
  localparam int RSF_AW = 3;
  localparam int RSF_DW = 5;
  localparam logic [3:0] RSF_LVL_OFFSET = 4'h2;
  // ****************************************
  // timing
  // ****************************************
  localparam int RSF_CLK_PERIOD_NS = 50;
  localparam int RSF_LINK_PERIOD_NS = 400;
  localparam int RSF_DIV = RSF_LINK_PERIOD_NS / RSF_CLK_PERIOD_NS;
  localparam logic [2:0] RSF_DIV_LAST = 3'(RSF_DIV - 1);
  // output clock high window, data changes at phase 1
  localparam logic [2:0] RSF_ALN_LO = 3'h1;
  localparam logic [2:0] RSF_ALN_HI = 3'h4;
  localparam logic [2:0] RSF_SHF_LO = 3'h3;
  localparam logic [2:0] RSF_SHF_HI = 3'h6;
endpackage : rsf_pkg

// [rsf_fifo.sv]
// Purpose: eight-entry synchronising fifo with programmable start level
// Assumes: write and read strobes are single-cycle on clk_i
// Notes: reading starts only after the programmed fill is reached
`timescale 1ns/10ps
`default_nettype none
module rsf_fifo
  import rsf_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // write side
  input wire logic wr_i,
  input wire logic [RSF_DW-1:0] wr_data_i,
  // read side
  input wire logic rd_tick_i,
  input wire logic [2:0] start_level_i,
  output logic rd_valid_o,
  output logic [RSF_DW-1:0] rd_data_o,
  // status
  output logic running_o,
  output logic overflow_o,
  output logic underflow_o
);
  logic [RSF_DW-1:0] mem_r [RSF_DEPTH];
  logic [RSF_AW:0] wp_r;
  logic [RSF_AW:0] rp_r;
  logic running_r;
  logic rd_valid_r;
  logic [RSF_DW-1:0] rd_data_r;
  logic ovf_r;
  logic unf_r;

  wire logic [RSF_AW:0] fill = wp_r - rp_r;
  wire logic empty = (fill == '0);
  wire logic full = (fill == (RSF_AW+1)'(RSF_DEPTH));
  // level + 2 entries ahead; a level past full starts at full
  wire logic [3:0] want = {1'b0, start_level_i} + RSF_LVL_OFFSET;
  wire logic [3:0] start_at = (want > 4'(RSF_DEPTH)) ? 4'(RSF_DEPTH) : want;
  wire logic pop = rd_tick_i && running_r && !empty;
  wire logic push = wr_i && (!full || pop);
  wire logic start = !running_r && (fill >= start_at);

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wp_r[RSF_AW-1:0]] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      running_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r <= '0;
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
    end else begin
      ovf_r <= wr_i && !push;
      unf_r <= rd_tick_i && running_r && empty;
      rd_valid_r <= pop;
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
        rd_data_r <= mem_r[rp_r[RSF_AW-1:0]];
      end
      // running out stops reading until the level is rebuilt
      if (start) begin
        running_r <= 1'b1;
      end else if (rd_tick_i && empty) begin
        running_r <= 1'b0;
      end
    end
  end

  assign rd_valid_o = rd_valid_r;
  assign rd_data_o = rd_data_r;
  assign running_o = running_r;
  assign overflow_o = ovf_r;
  assign underflow_o = unf_r;
endmodule : rsf_fifo
`default_nettype wire

// [rsf_chk.sv]
// Purpose: port checks for the sync fifo and skew control block
// Assumes: one clock domain, sync active-high reset
// Notes: ctrl writes may bend one rx clock pulse, so those are skipped
`timescale 1ns/10ps
`default_nettype none
module rsf_chk
  import rsf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic tx_core_valid_o,
  input wire logic [RSF_DW-1:0] tx_core_data_o,
  input wire logic rgmii_rxc_o
);
  logic ack_d_r;
  always_ff @(posedge clk_i) begin
    ack_d_r <= wb_ack_o;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_rst_idle;
    $fell(rst_i) |-> !wb_ack_o && !tx_core_valid_o && !rgmii_rxc_o;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("outputs busy after reset");
  property p_ack_due; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_due: assert property (p_ack_due)
    else $error("no ack one cycle after request");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack longer than one cycle");
  property p_ack_why; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  a_ack_why: assert property (p_ack_why)
    else $error("ack without request");
  property p_tx_rate; tx_core_valid_o |=> !tx_core_valid_o [*7]; endproperty
  a_tx_rate: assert property (p_tx_rate)
    else $error("tx reads closer than eight cycles");
  property p_tx_hold;
    !tx_core_valid_o && !$past(rst_i) |-> $stable(tx_core_data_o);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx data moved without a read");
  // a ctrl write may shift the window mid-pulse, so those attempts drop
  property p_rxc_high;
    disable iff (rst_i || wb_ack_o || ack_d_r)
    $rose(rgmii_rxc_o) |=> rgmii_rxc_o [*3] ##1 !rgmii_rxc_o;
  endproperty
  a_rxc_high: assert property (p_rxc_high)
    else $error("rx clock high time wrong");
  property p_rxc_per;
    disable iff (rst_i || wb_ack_o || ack_d_r)
    $rose(rgmii_rxc_o) |-> ##8 $rose(rgmii_rxc_o);
  endproperty
  a_rxc_per: assert property (p_rxc_per)
    else $error("rx clock period wrong");
endmodule : rsf_chk
`default_nettype wire

// [rsf_mac.sv]
// Purpose: mac side of the link: sends nibbles, captures rx pins
// Assumes: one nibble and ctl per rising link clock edge
// Notes: the link clock stands low between nibbles
`timescale 1ns/10ps
`default_nettype none
module rsf_mac (
  // transmit pins toward the block
  output logic txc_o,
  output logic [4:0] tx_o,
  // receive pins from the block
  input wire logic rxc_i,
  input wire logic [4:0] rx_i,
  output logic [4:0] rx_last_o
);
  initial begin
    txc_o = 1'b0;
    tx_o = 5'h00;
    rx_last_o = 5'h00;
  end
  // call just after a rising clk edge: nbas keep pin moves off the sampling
  // rise mid-symbol; released data shows its inverse, not a stale copy
  // data drops late in the high half so no pin is set twice in one step
  task automatic send(input logic [4:0] v);
    tx_o <= v;
    #200 txc_o <= 1'b1;
    #150 tx_o <= ~v;
    #50 txc_o <= 1'b0;
  endtask : send
  // falling edge is clear of data changes under both skew settings
  always @(negedge rxc_i) begin
    rx_last_o <= rx_i;
  end
endmodule : rsf_mac
`default_nettype wire

// [rsf_tb.sv]
// Purpose: self-checking bench for the sync fifo and skew control block
// Assumes: mac model drives the transmit pins
// Notes: reading starts once level plus two entries are held
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("wrong value %s expected %h seen %h", n, e, a); end end
module testbench;
  import rsf_pkg::*;
  localparam logic [7:0] CTRL_A = {RSF_IDX_CTRL[5:0], 2'b00};
  localparam logic [7:0] STAT_A = {RSF_IDX_STAT[5:0], 2'b00};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, rxv = 1'b0;
  logic rx_msb = 1'b0, tx_msb = 1'b0, ack, txc, txv, rxc;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [4:0] rxd = 5'h00, txd, rx_last;
  wire logic [4:0] txo;
  wire logic [4:0] rxo;
  int err_count = 0, checked = 0, cyc_cnt = 0, tx_cnt = 0;
  always #25 clk_i = ~clk_i;
  rsf_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .rx_level_msb_i(rx_msb),
    .tx_level_msb_i(tx_msb), .rgmii_txc_i(txc), .rgmii_txd_i(txo[3:0]),
    .rgmii_tx_ctl_i(txo[4]), .tx_core_valid_o(txv), .tx_core_data_o(txd),
    .rx_core_valid_i(rxv), .rx_core_data_i(rxd), .rgmii_rxc_o(rxc),
    .rgmii_rxd_o(rxo[3:0]), .rgmii_rx_ctl_o(rxo[4]));
  rsf_mac mac (.txc_o(txc), .tx_o(txo), .rxc_i(rxc), .rx_i(rxo),
    .rx_last_o(rx_last));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (txv === 1'b1) begin
      tx_cnt <= tx_cnt + 1;
    end
    if (cyc_cnt == 20000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic t_regs();
    wb(1'b0, CTRL_A, 32'h0);
    `CHK("ctrl reset", 32'h000000D0, q)
    wb(1'b0, 8'h04, 32'h0);
    `CHK("unmapped read", 32'h0, q)
    wb(1'b1, CTRL_A, 32'h0000FFFF);
    wb(1'b0, CTRL_A, 32'h0);
    `CHK("ctrl readback", 32'h00000BFF, q)
    $display("test regs done");
  endtask : t_regs
  task automatic t_tx(input logic [15:0] c, input logic m, input int n);
    int c0;
    int k;
    tx_msb <= m;
    wb(1'b1, CTRL_A, {16'h0, c});
    c0 = tx_cnt;
    for (k = 0; k < n - 1; k++) mac.send(5'h10 + 5'(k));
    repeat (16) @(posedge clk_i);
    `CHK("tx early", c0, tx_cnt)
    mac.send(5'h10 + 5'(n - 1));
    for (k = 0; k < 40 && tx_cnt == c0; k++) @(posedge clk_i);
    `CHK("tx first", 5'h10, txd)
    repeat (80) @(posedge clk_i);
    `CHK("tx count", c0 + n, tx_cnt)
    wb(1'b0, STAT_A, 32'h0);
    `CHK("tx status", 32'h00000008, q)
    wb(1'b1, STAT_A, 32'h0000000F);
    $display("test tx done");
  endtask : t_tx
  task automatic t_rx(input logic [15:0] c, input logic m, input int n);
    int k;
    rx_msb <= m;
    wb(1'b1, CTRL_A, {16'h0, c});
    for (k = 0; k < n; k++) begin
      if (k == n - 1) begin
        repeat (24) @(posedge clk_i);
        `CHK("rx early", 5'h00, rx_last)
      end
      rxd <= 5'h08 + 5'(k);
      rxv <= 1'b1;
      @(posedge clk_i);
      rxv <= 1'b0;
      @(posedge clk_i);
    end
    for (k = 0; k < 40 && rx_last === 5'h00; k++) @(posedge clk_i);
    `CHK("rx first", 5'h08, rx_last)
    repeat (80) @(posedge clk_i);
    `CHK("rx idle", 5'h00, rx_last)
    wb(1'b0, STAT_A, 32'h0);
    `CHK("rx status", 32'h00000002, q)
    wb(1'b1, STAT_A, 32'h0000000F);
    $display("test rx done");
  endtask : t_rx
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_tx(16'h00D0, 1'b0, 4);
    t_tx(16'h00C2, 1'b0, 2);
    t_tx(16'h008A, 1'b1, 7);
    t_rx(16'h00B1, 1'b1, 7);
    t_rx(16'h00D0, 1'b0, 4);
    stop_test();
  end
endmodule : testbench
bind rsf_top rsf_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .tx_core_valid_o(tx_core_valid_o), .tx_core_data_o(tx_core_data_o),
  .rgmii_rxc_o(rgmii_rxc_o));
`default_nettype wire
